// ===== logic/pw_lock_pkg.sv
// shared constants and types for the parameter password lock
package pw_lock_pkg;
  // ****************************************
  // parameter numbers and values
  // ****************************************
  localparam logic [9:0] LOCK_LEVEL_PARAM = 10'h128; // lock level select
  localparam logic [9:0] PASSWORD_PARAM = 10'h129; // password entry and error count
  localparam logic [15:0] LEVEL_NONE = 16'h270F; // no lock, also reset value
  localparam logic [15:0] PW_NONE = 16'h270F; // no password, also reset value
  localparam logic [15:0] PW_MIN = 16'h03E8; // lowest password
  localparam logic [15:0] PW_MAX = 16'h270E; // highest password
  localparam logic [15:0] PW_IGNORED_ZERO = 16'h0000; // write accepted, no effect
  localparam logic [15:0] LEVEL_GROUP = 16'h0063; // user group level
  localparam logic [15:0] LEVEL_COUNT_BASE = 16'h0064; // first counting level
  localparam logic [15:0] LEVEL_COUNT_TOP = 16'h006A; // last counting numeric level
  localparam logic [15:0] LEVEL_COUNT_GROUP = 16'h00C7; // counting user group level
  localparam logic [15:0] LEVEL_PLAIN_TOP = 16'h0006; // last plain numeric level
  localparam logic [15:0] EXT_DISP_ALL = 16'h0000; // extended display shows all
  localparam logic [2:0] ERR_RESET = 3'h0; // error count after reset
  localparam logic [2:0] ERR_MAX = 3'h5; // lockout count
  localparam logic [15:0] CODE_ALL_A = 16'h9966; // all parameter clear codes
  localparam logic [15:0] CODE_ALL_B = 16'h55AA;
  localparam logic [15:0] CODE_PAR_A = 16'h9696; // parameter clear codes
  localparam logic [15:0] CODE_PAR_B = 16'h5A5A;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {SRC_PANEL, SRC_RS485, SRC_OPTION} src_t;

  typedef struct packed {
    logic write; // 1 write, 0 read
    src_t src; // command source
    logic [9:0] param; // parameter number
    logic [15:0] data; // write data
  } req_t;

  typedef struct packed {
    logic ok; // access granted
    logic lock_err; // refused by the password lock
    logic unlock_err; // unlock refused: password mismatch or lockout
    logic [15:0] rdata; // read data of the two lock parameters
  } resp_t;

  typedef struct packed {
    logic loc_rd;
    logic loc_wr;
    logic rs_rd;
    logic opt_rd;
    logic net_wr;
  } perm_t;

  // legal lock level settings
  function automatic logic level_valid(input logic [15:0] lv);
    level_valid = (lv <= LEVEL_PLAIN_TOP) || (lv == LEVEL_GROUP) || (lv == LEVEL_NONE) ||
      ((lv >= LEVEL_COUNT_BASE) && (lv <= LEVEL_COUNT_TOP)) || (lv == LEVEL_COUNT_GROUP);
  endfunction : level_valid
endpackage : pw_lock_pkg

// ===== logic/lock_perm_decode.sv
// decodes a lock level into per-source read and write permissions
`timescale 1ns/100ps
`default_nettype none
module lock_perm_decode (
  input wire logic [15:0] level, // lock level setting
  input wire logic in_group, // parameter registered in the user group
  output pw_lock_pkg::perm_t perm // resulting permissions
);
  logic [15:0] base;

  // fold counting levels onto their plain twins, then look up
  always_comb begin
    base = 16'h0000;
    perm = '0;
    if (level == pw_lock_pkg::LEVEL_NONE) begin
      perm = 5'b11111; // see RL9
    end else if (level == pw_lock_pkg::LEVEL_GROUP || level == pw_lock_pkg::LEVEL_COUNT_GROUP) begin
      perm = in_group ? 5'b11111 : 5'b00010; // see RL12
    end else begin
      base = (level >= pw_lock_pkg::LEVEL_COUNT_BASE) ? level - pw_lock_pkg::LEVEL_COUNT_BASE : level;
      case (base)
        16'h0000: perm = 5'b00000; // see RL9
        16'h0001: perm = 5'b10110; // see RL10
        16'h0002: perm = 5'b10111; // see RL10
        16'h0003: perm = 5'b11110; // see RL10
        16'h0004: perm = 5'b00010; // see RL11
        16'h0005: perm = 5'b00111; // see RL11
        16'h0006: perm = 5'b11010; // see RL11
        default: perm = 5'b00000;
      endcase
    end
  end
endmodule : lock_perm_decode
`default_nettype wire

// ===== logic/parameter_password_lock.sv
// parameter password lock: access gate, password store and clear handling
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RL1: password 1000..9998 registers, applies lock level
// RL2: unlocked level 9999 accepts only with display 0
// RL3: counting levels show error count, else 0
// RL4: after fifth error correct password ignored
// RL5: all clear releases lock unless motor runs, clears parameters
// RL6: matching password unlocks, mismatch flags error
// RL7: registered password never reads back, 0..5 only
// RL8: writing 0 or 9999 accepted, no effect
// RL9: level sets per-source permissions; 9999 all, 0 none
// RL10: levels 1,2,3 per-source read/write table
// RL11: levels 4,5,6 per-source read/write table
// RL12: group levels: registered only, else level 4
// RL13: lock parameters always accessible under group limit
// RL14: extended display block still refuses reads; network reads while unlocked are granted
// RL15: write protect block still refuses writes
// RL16: full block with option installed trips
// RL17: internal parameter updates always pass
// RL18: locked access refused with lock error
// RL19: lock parameters writable despite write protect
// RL20: no all clear while motor runs
// RL21: all clear codes unlock from any source
// RL22: parameter clear codes unlock only via option
// RL23: error count steps once, saturates, clears on clear
module parameter_password_lock (
  input wire logic sys_clk, // 20 MHz clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic req_valid, // parameter access request, one cycle
  input wire pw_lock_pkg::req_t req, // access request fields
  input wire logic in_user_group, // requested parameter is in the user group
  input wire logic disp_blocks_read, // extended display hides this parameter
  input wire logic wp_blocks_write, // write protect blocks this parameter
  input wire logic [15:0] extended_display_select, // extended display setting
  input wire logic rs485_is_local, // local command source is the RS-485 link
  input wire logic option_installed, // network option fitted
  input wire logic motor_running, // drive is running
  input wire logic int_wr_valid, // internal parameter update request
  output logic int_wr_grant, // internal update granted
  input wire logic clr_valid, // clear request, one cycle
  input wire pw_lock_pkg::src_t clr_src, // clear request source
  input wire logic [15:0] clr_code, // clear data code
  output logic resp_valid, // access answer, one cycle
  output pw_lock_pkg::resp_t resp, // access answer fields
  output logic clr_done, // clear answer, one cycle
  output logic clr_ok, // clear accepted
  output logic all_clear_pulse, // reset all other parameters
  output logic param_clear_pulse, // reset ordinary parameters
  output logic [15:0] lock_level_select, // current lock level
  output logic locked, // password registered and active
  output logic option_fault_trip // option fault, held until clear
);
  // ****************************************
  // state
  // ****************************************
  logic [15:0] level_reg;
  logic [15:0] level_next;
  logic [15:0] pw_reg;
  logic [15:0] pw_next;
  logic [2:0] err_reg;
  logic [2:0] err_next;
  logic trip_reg;
  logic trip_next;
  // answer registers, one-cycle strobes
  logic resp_valid_reg;
  logic resp_valid_next;
  pw_lock_pkg::resp_t resp_reg;
  pw_lock_pkg::resp_t resp_next;
  logic clr_done_reg;
  logic clr_done_next;
  logic clr_ok_reg;
  logic clr_ok_next;
  logic all_clr_reg;
  logic all_clr_next;
  logic par_clr_reg;
  logic par_clr_next;

  // decode of the current request
  pw_lock_pkg::perm_t perm;
  logic is_locked;
  logic counting;
  logic lockout;
  logic network;
  logic local_src;
  logic lock_ok;
  logic is_lock_param;
  logic all_code;
  logic par_code;

  // permissions for the requested parameter under the current level
  lock_perm_decode u_perm (
    .level(level_reg),
    .in_group(in_user_group),
    .perm(perm)
  );

  // ****************************************
  // status decode
  // ****************************************
  // lock status and source class of the request
  assign is_locked = (pw_reg != pw_lock_pkg::PW_NONE);
  assign counting = ((level_reg >= pw_lock_pkg::LEVEL_COUNT_BASE) &&
    (level_reg <= pw_lock_pkg::LEVEL_COUNT_TOP)) ||
    (level_reg == pw_lock_pkg::LEVEL_COUNT_GROUP); // see RL3
  assign lockout = counting && (err_reg == pw_lock_pkg::ERR_MAX); // see RL4
  assign local_src = (req.src == pw_lock_pkg::SRC_PANEL) ||
    (rs485_is_local && req.src == pw_lock_pkg::SRC_RS485);
  assign network = !local_src;
  assign is_lock_param = (req.param == pw_lock_pkg::LOCK_LEVEL_PARAM) ||
    (req.param == pw_lock_pkg::PASSWORD_PARAM);
  assign all_code = (clr_code == pw_lock_pkg::CODE_ALL_A) ||
    (clr_code == pw_lock_pkg::CODE_ALL_B);
  assign par_code = (clr_code == pw_lock_pkg::CODE_PAR_A) ||
    (clr_code == pw_lock_pkg::CODE_PAR_B);
  // internal updates are never held back
  assign int_wr_grant = int_wr_valid; // see RL17

  // lock verdict for an ordinary parameter
  always_comb begin
    lock_ok = 1'b1;
    if (is_locked) begin
      if (local_src) begin
        lock_ok = req.write ? perm.loc_wr : perm.loc_rd; // see RL9
      end else if (req.write) begin
        lock_ok = perm.net_wr; // see RL10
      end else if (req.src == pw_lock_pkg::SRC_OPTION) begin
        lock_ok = perm.opt_rd; // see RL11
      end else begin
        lock_ok = perm.rs_rd; // see RL10
      end
    end
  end

  // ****************************************
  // access, password and clear handling
  // ****************************************
  always_comb begin
    // hold state, no answer by default
    level_next = level_reg;
    pw_next = pw_reg;
    err_next = err_reg;
    trip_next = trip_reg;
    resp_valid_next = 1'b0;
    resp_next = '0;
    clr_done_next = 1'b0;
    clr_ok_next = 1'b0;
    all_clr_next = 1'b0;
    par_clr_next = 1'b0;
    // full block with the option fitted trips and holds
    if (is_locked && option_installed &&
        (level_reg == 16'h0000 || level_reg == pw_lock_pkg::LEVEL_COUNT_BASE)) begin
      trip_next = 1'b1; // see RL16
    end
    // access, answered at the next edge
    if (req_valid) begin
      resp_valid_next = 1'b1;
      if (req.param == pw_lock_pkg::LOCK_LEVEL_PARAM) begin
        // lock parameters bypass group and write protect limits, see RL13 and RL19
        if (!req.write) begin
          resp_next.ok = 1'b1;
          resp_next.rdata = level_reg;
        end else if (is_locked) begin
          resp_next.lock_err = 1'b1; // see RL18
        end else if (pw_lock_pkg::level_valid(req.data) &&
            extended_display_select == pw_lock_pkg::EXT_DISP_ALL) begin
          resp_next.ok = 1'b1;
          level_next = req.data;
        end
      end else if (req.param == pw_lock_pkg::PASSWORD_PARAM) begin
        if (!req.write) begin
          resp_next.ok = 1'b1;
          if (is_locked) begin
            if (counting) begin
              resp_next.rdata = {13'h0000, err_reg}; // see RL3
            end else begin
              resp_next.rdata = 16'h0000; // see RL7
            end
          end else begin
            resp_next.rdata = pw_lock_pkg::PW_NONE;
          end
        end else if (req.data == pw_lock_pkg::PW_IGNORED_ZERO ||
            req.data == pw_lock_pkg::PW_NONE) begin
          resp_next.ok = 1'b1; // see RL8
        end else if (req.data < pw_lock_pkg::PW_MIN ||
            req.data > pw_lock_pkg::PW_MAX) begin
          resp_next.ok = 1'b0;
        end else if (!is_locked) begin
          if (level_reg == pw_lock_pkg::LEVEL_NONE) begin
            resp_next.ok = (extended_display_select ==
              pw_lock_pkg::EXT_DISP_ALL); // see RL2
          end else begin
            resp_next.ok = 1'b1;
            pw_next = req.data; // see RL1
            err_next = pw_lock_pkg::ERR_RESET;
          end
        end else if (lockout) begin
          resp_next.ok = 1'b1; // see RL4
          resp_next.unlock_err = 1'b1;
        end else if (req.data == pw_reg) begin
          resp_next.ok = 1'b1;
          pw_next = pw_lock_pkg::PW_NONE; // see RL6
          err_next = pw_lock_pkg::ERR_RESET;
        end else begin
          resp_next.ok = 1'b1;
          resp_next.unlock_err = 1'b1; // see RL6
          if (counting && err_reg != pw_lock_pkg::ERR_MAX) begin
            err_next = err_reg + 3'h1; // see RL23
          end
        end
      end else if (!lock_ok) begin
        resp_next.lock_err = 1'b1; // see RL18
      end else if (!req.write && disp_blocks_read &&
          !(network && !is_locked)) begin
        resp_next.ok = 1'b0; // see RL14
      end else if (req.write && wp_blocks_write) begin
        resp_next.ok = 1'b0; // see RL15
      end else begin
        resp_next.ok = 1'b1;
      end
      // a granted lock parameter never shows a lock error
      if (is_lock_param && resp_next.ok) begin
        resp_next.lock_err = 1'b0;
      end
    end
    // clear request, wins over an access
    if (clr_valid) begin
      clr_done_next = 1'b1;
      if (motor_running) begin
        clr_ok_next = 1'b0; // see RL20
      end else if (all_code) begin
        // any source releases the lock and resets everything, see RL5 RL21
        clr_ok_next = 1'b1;
        all_clr_next = 1'b1;
        level_next = pw_lock_pkg::LEVEL_NONE;
        pw_next = pw_lock_pkg::PW_NONE;
        err_next = pw_lock_pkg::ERR_RESET; // see RL23
        trip_next = 1'b0;
      end else if (par_code &&
          (!is_locked || clr_src == pw_lock_pkg::SRC_OPTION)) begin
        // only the option may release the lock this way, see RL22
        clr_ok_next = 1'b1;
        par_clr_next = 1'b1;
        level_next = pw_lock_pkg::LEVEL_NONE;
        pw_next = pw_lock_pkg::PW_NONE;
        err_next = pw_lock_pkg::ERR_RESET;
        trip_next = 1'b0;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // lock state: level, password, errors, trip
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      level_reg <= pw_lock_pkg::LEVEL_NONE;
      pw_reg <= pw_lock_pkg::PW_NONE;
      err_reg <= pw_lock_pkg::ERR_RESET;
      trip_reg <= 1'b0;
    end else begin
      level_reg <= level_next;
      pw_reg <= pw_next;
      err_reg <= err_next;
      trip_reg <= trip_next;
    end
  end

  // answers, idle after reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      resp_valid_reg <= 1'b0;
      resp_reg <= '0;
      clr_done_reg <= 1'b0;
      clr_ok_reg <= 1'b0;
      all_clr_reg <= 1'b0;
      par_clr_reg <= 1'b0;
    end else begin
      resp_valid_reg <= resp_valid_next;
      resp_reg <= resp_next;
      clr_done_reg <= clr_done_next;
      clr_ok_reg <= clr_ok_next;
      all_clr_reg <= all_clr_next;
      par_clr_reg <= par_clr_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // answers, level and trip straight from flip-flops, locked decoded from pw_reg
  assign resp_valid = resp_valid_reg;
  assign resp = resp_reg;
  assign clr_done = clr_done_reg;
  assign clr_ok = clr_ok_reg;
  assign all_clear_pulse = all_clr_reg;
  assign param_clear_pulse = par_clr_reg;
  assign lock_level_select = level_reg;
  assign locked = is_locked;
  assign option_fault_trip = trip_reg;
endmodule : parameter_password_lock
`default_nettype wire

// ===== tb/pw_lock_monitor.sv
// port assertions for the parameter password lock
`timescale 1ns/100ps
`default_nettype none
module pw_lock_monitor (
  input wire logic sys_clk, // clock
  input wire logic arst_n, // reset, active low
  input wire logic req_valid, // access request
  input wire pw_lock_pkg::req_t req, // request fields
  input wire logic int_wr_valid, // internal update request
  input wire logic int_wr_grant, // internal update grant
  input wire logic clr_valid, // clear request
  input wire pw_lock_pkg::src_t clr_src, // clear source
  input wire logic [15:0] clr_code, // clear code
  input wire logic motor_running, // drive running
  input wire logic resp_valid, // answer strobe
  input wire pw_lock_pkg::resp_t resp, // answer fields
  input wire logic clr_done, // clear answer
  input wire logic clr_ok, // clear accepted
  input wire logic all_clear_pulse, // all clear strobe
  input wire logic [15:0] lock_level_select, // lock level
  input wire logic locked, // lock active
  input wire logic option_fault_trip // option fault
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ****
  // clear sequences
  // ****
  sequence all_clr_s;
    clr_valid && !motor_running &&
      (clr_code == pw_lock_pkg::CODE_ALL_A || clr_code == pw_lock_pkg::CODE_ALL_B);
  endsequence
  sequence released_s;
    clr_done && clr_ok && all_clear_pulse && !locked &&
      lock_level_select == pw_lock_pkg::LEVEL_NONE;
  endsequence
  // ****
  // properties
  // ****
  resp_timing_a: assert property (req_valid |=> resp_valid)
    else $error("access answer missing");
  clear_timing_a: assert property (clr_valid |=> clr_done)
    else $error("clear answer missing");
  internal_grant_a: assert property (int_wr_valid |-> int_wr_grant)
    else $error("internal update refused");
  all_clear_a: assert property (all_clr_s |=> released_s)
    else $error("all clear did not release");
  motor_refuse_a: assert property (clr_valid && motor_running |=> clr_done && !clr_ok
    && !all_clear_pulse) else $error("clear taken while running");
  local_par_clear_a: assert property (clr_valid && locked && clr_src != pw_lock_pkg::SRC_OPTION
    && (clr_code == pw_lock_pkg::CODE_PAR_A || clr_code == pw_lock_pkg::CODE_PAR_B)
    |=> !clr_ok && locked) else $error("local parameter clear unlocked");
  pw_readback_a: assert property (req_valid && !req.write && !clr_valid && locked &&
    req.param == pw_lock_pkg::PASSWORD_PARAM |=> resp.rdata <= 16'h0005)
    else $error("password read back out of range");
  trip_sticky_a: assert property (option_fault_trip && !clr_valid |=> option_fault_trip)
    else $error("option fault dropped");
  lock_err_refuse_a: assert property (resp_valid && resp.lock_err |-> !resp.ok)
    else $error("lock error with grant");
  level_locked_a: assert property (req_valid && req.write && locked && !clr_valid &&
    req.param == pw_lock_pkg::LOCK_LEVEL_PARAM |=> resp.lock_err && $stable(lock_level_select))
    else $error("lock level changed while locked");
endmodule : pw_lock_monitor
bind parameter_password_lock pw_lock_monitor pw_lock_monitor_inst (
  .sys_clk(sys_clk), .arst_n(arst_n), .req_valid(req_valid), .req(req),
  .int_wr_valid(int_wr_valid), .int_wr_grant(int_wr_grant), .clr_valid(clr_valid),
  .clr_src(clr_src), .clr_code(clr_code), .motor_running(motor_running),
  .resp_valid(resp_valid), .resp(resp), .clr_done(clr_done), .clr_ok(clr_ok),
  .all_clear_pulse(all_clear_pulse), .lock_level_select(lock_level_select),
  .locked(locked), .option_fault_trip(option_fault_trip));
`default_nettype wire

// ===== tb/host_model.sv
// command source model issuing parameter accesses and clears
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic sys_clk, // clock
  input wire logic resp_valid, // answer strobe
  input wire pw_lock_pkg::resp_t resp, // answer fields
  input wire logic clr_done, // clear answer strobe
  input wire logic clr_ok, // clear accepted
  output var logic req_valid, // access request
  output var pw_lock_pkg::req_t req, // request fields
  output var logic clr_valid, // clear request
  output var pw_lock_pkg::src_t clr_src, // clear source
  output var logic [15:0] clr_code, // clear code
  output var logic got, // answer strobe seen in its cycle
  output var pw_lock_pkg::resp_t rsp, // captured answer
  output var logic got_ok // captured clear result
);
  // idle request lines at time zero
  initial begin
    req_valid = 1'b0;
    req = '0;
    clr_valid = 1'b0;
    clr_src = pw_lock_pkg::SRC_PANEL;
    clr_code = 16'h0000;
  end
  // one access: held over its taken edge, answer captured just after that edge
  task automatic access(input logic w, input pw_lock_pkg::src_t s, input logic [9:0] p,
    input logic [15:0] d);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= '{write: w, src: s, param: p, data: d};
    @(posedge sys_clk);
    req_valid <= 1'b0;
    req.data <= ~d; // released data does not keep its value
    #1;
    got = resp_valid;
    rsp = resp;
  endtask : access
  // one clear request with its answer
  task automatic clear(input pw_lock_pkg::src_t s, input logic [15:0] c);
    @(posedge sys_clk);
    clr_valid <= 1'b1;
    clr_src <= s;
    clr_code <= c;
    @(posedge sys_clk);
    clr_valid <= 1'b0;
    clr_code <= ~c;
    #1;
    got = clr_done;
    got_ok = clr_ok;
  endtask : clear
endmodule : host_model
`default_nettype wire

// ===== tb/tb_parameter_password_lock.sv
// self-checking bench for the parameter password lock
`timescale 1ns/100ps
`default_nettype none
module tb_parameter_password_lock;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic in_user_group = 1'b0, disp_blocks_read = 1'b0, wp_blocks_write = 1'b0;
  logic rs485_is_local = 1'b0, option_installed = 1'b0, motor_running = 1'b0;
  logic int_wr_valid = 1'b0;
  logic [15:0] extended_display_select = 16'h0000;
  logic req_valid, clr_valid, resp_valid, clr_done, clr_ok, got, got_ok, int_wr_grant;
  logic all_clear_pulse, param_clear_pulse, locked, option_fault_trip;
  logic [15:0] clr_code, lock_level_select;
  pw_lock_pkg::req_t req;
  pw_lock_pkg::resp_t resp, rsp;
  pw_lock_pkg::src_t clr_src;
  int errors = 0, checked = 0, cycles = 0;
  localparam logic [15:0] PW = 16'h04D2;
  localparam logic [9:0] PAR = 10'h003;
  always #25 sys_clk = ~sys_clk;
  parameter_password_lock parameter_password_lock_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .req_valid(req_valid), .req(req), .in_user_group(in_user_group),
    .disp_blocks_read(disp_blocks_read), .wp_blocks_write(wp_blocks_write),
    .extended_display_select(extended_display_select), .rs485_is_local(rs485_is_local),
    .option_installed(option_installed), .motor_running(motor_running),
    .int_wr_valid(int_wr_valid), .int_wr_grant(int_wr_grant), .clr_valid(clr_valid),
    .clr_src(clr_src), .clr_code(clr_code), .resp_valid(resp_valid), .resp(resp),
    .clr_done(clr_done), .clr_ok(clr_ok), .all_clear_pulse(all_clear_pulse),
    .param_clear_pulse(param_clear_pulse),
    .lock_level_select(lock_level_select), .locked(locked),
    .option_fault_trip(option_fault_trip));
  host_model host_model_inst (.sys_clk(sys_clk), .resp_valid(resp_valid), .resp(resp),
    .clr_done(clr_done), .clr_ok(clr_ok), .req_valid(req_valid), .req(req),
    .clr_valid(clr_valid), .clr_src(clr_src), .clr_code(clr_code), .got(got), .rsp(rsp),
    .got_ok(got_ok));
  // ****
  // checking and closing
  // ****
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  // cycle ceiling against a hang
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      complete_run();
    end
  end
  // ****
  // scenarios
  // ****
  task automatic pw_write(input pw_lock_pkg::src_t s, input logic [15:0] d);
    host_model_inst.access(1'b1, s, pw_lock_pkg::PASSWORD_PARAM, d);
  endtask : pw_write
  task automatic lock_with(input logic [15:0] lv);
    host_model_inst.access(1'b1, pw_lock_pkg::SRC_PANEL, pw_lock_pkg::LOCK_LEVEL_PARAM, lv);
    pw_write(pw_lock_pkg::SRC_PANEL, PW);
    check("locked", 16'(locked), 16'h0001);
  endtask : lock_with
  task automatic t_reset_and_free;
    check("level", lock_level_select, pw_lock_pkg::LEVEL_NONE);
    host_model_inst.access(1'b0, pw_lock_pkg::SRC_PANEL, pw_lock_pkg::PASSWORD_PARAM, 16'h0000);
    check("pw read", rsp.rdata, pw_lock_pkg::PW_NONE);
    check("answer strobe", 16'(got), 16'h0001);
    @(posedge sys_clk) extended_display_select <= 16'h0001;
    pw_write(pw_lock_pkg::SRC_PANEL, PW);
    check("hidden pw ok", 16'(rsp.ok), 16'h0000);
    @(posedge sys_clk) extended_display_select <= 16'h0000;
    pw_write(pw_lock_pkg::SRC_PANEL, pw_lock_pkg::PW_NONE);
    check("ignored ok", 16'(rsp.ok), 16'h0001);
    check("free locked", 16'(locked), 16'h0000);
    @(posedge sys_clk) {disp_blocks_read, wp_blocks_write} <= 2'b11;
    host_model_inst.access(1'b0, pw_lock_pkg::SRC_PANEL, PAR, 16'h0000);
    check("hidden read", 16'(rsp.ok), 16'h0000);
    host_model_inst.access(1'b1, pw_lock_pkg::SRC_PANEL, PAR, 16'h0001);
    check("protected write", 16'(rsp.ok), 16'h0000);
    @(posedge sys_clk) {disp_blocks_read, wp_blocks_write} <= 2'b00;
  endtask : t_reset_and_free
  task automatic t_table;
    logic [4:0] perm [7] = '{5'h00, 5'h16, 5'h17, 5'h1E, 5'h02, 5'h07, 5'h1A};
    pw_lock_pkg::src_t s;
    for (int lv = 0; lv < 7; lv++) begin
      lock_with(16'(lv));
      for (int k = 0; k < 5; k++) begin
        s = (k < 2) ? pw_lock_pkg::SRC_PANEL : ((k == 2) ? pw_lock_pkg::SRC_RS485
          : pw_lock_pkg::SRC_OPTION);
        host_model_inst.access(k == 1 || k == 4, s, PAR, 16'h0001);
        check("perm ok", 16'(rsp.ok), 16'(perm[lv][4-k]));
        check("lock err", 16'(rsp.lock_err), 16'(!perm[lv][4-k]));
      end
      pw_write(pw_lock_pkg::SRC_PANEL, PW + 16'h0001);
      host_model_inst.access(1'b0, pw_lock_pkg::SRC_PANEL, pw_lock_pkg::PASSWORD_PARAM, 16'h0000);
      check("plain count", rsp.rdata, 16'h0000);
      pw_write(pw_lock_pkg::SRC_PANEL, PW);
      check("unlocked", 16'(locked), 16'h0000);
    end
  endtask : t_table
  task automatic t_lockout;
    @(posedge sys_clk) option_installed <= 1'b1;
    lock_with(pw_lock_pkg::LEVEL_COUNT_BASE);
    host_model_inst.access(1'b1, pw_lock_pkg::SRC_PANEL, pw_lock_pkg::LOCK_LEVEL_PARAM, 16'h0003);
    check("level lock err", 16'(rsp.lock_err), 16'h0001);
    check("trip", 16'(option_fault_trip), 16'h0001);
    for (int i = 1; i < 7; i++) begin
      pw_write(pw_lock_pkg::SRC_PANEL, PW + 16'h0001);
      check("unlock err", 16'(rsp.unlock_err), 16'h0001);
      host_model_inst.access(1'b0, pw_lock_pkg::SRC_OPTION, pw_lock_pkg::PASSWORD_PARAM, 16'h0000);
      check("count", rsp.rdata, (i < 5) ? 16'(i) : 16'h0005);
    end
    pw_write(pw_lock_pkg::SRC_PANEL, PW);
    check("lockout", 16'(locked), 16'h0001);
    @(posedge sys_clk) int_wr_valid <= 1'b1;
    #1;
    check("int grant", 16'(int_wr_grant), 16'h0001);
    @(posedge sys_clk) int_wr_valid <= 1'b0;
    host_model_inst.clear(pw_lock_pkg::SRC_PANEL, pw_lock_pkg::CODE_PAR_A);
    check("panel par clr", 16'(got_ok), 16'h0000);
    @(posedge sys_clk) motor_running <= 1'b1;
    host_model_inst.clear(pw_lock_pkg::SRC_PANEL, pw_lock_pkg::CODE_ALL_A);
    check("run clr", 16'(got_ok), 16'h0000);
    @(posedge sys_clk) motor_running <= 1'b0;
    host_model_inst.clear(pw_lock_pkg::SRC_OPTION, pw_lock_pkg::CODE_PAR_B);
    check("opt par clr", 16'(locked), 16'h0000);
    check("trip cleared", 16'(option_fault_trip), 16'h0000);
    check("par pulse", 16'(param_clear_pulse), 16'h0001);
    lock_with(pw_lock_pkg::LEVEL_COUNT_GROUP);
    @(posedge sys_clk) in_user_group <= 1'b1;
    host_model_inst.access(1'b1, pw_lock_pkg::SRC_PANEL, PAR, 16'h0001);
    check("group write", 16'(rsp.ok), 16'h0001);
    @(posedge sys_clk) in_user_group <= 1'b0;
    host_model_inst.access(1'b0, pw_lock_pkg::SRC_PANEL, PAR, 16'h0000);
    check("ungrouped read", 16'(rsp.lock_err), 16'h0001);
    host_model_inst.clear(pw_lock_pkg::SRC_RS485, pw_lock_pkg::CODE_ALL_B);
    check("all clr", 16'(got_ok & !locked), 16'h0001);
    check("level cleared", lock_level_select, pw_lock_pkg::LEVEL_NONE);
  endtask : t_lockout
  // reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset_and_free();
    t_table();
    t_lockout();
    complete_run();
  end
endmodule : tb_parameter_password_lock
`default_nettype wire
